/* File: rtl/uffc_top.sv */
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module uffc_top #(
   parameter int BAUD_W = 8
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic [1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic serial_tx_pin_o,
   output logic serial_tx_oe_o,
   input wire logic serial_rx_pin_i
);
   if (BAUD_W < 2 || BAUD_W > uffc_pkg::DATA_W) begin : g_baud_chk
      $error("BAUD_W must lie between 2 and the register width");
   end

   // Control fields
   logic enable;
   logic word_len_nine_select;
   logic parity_enable_bit;
   logic parity_odd_select;
   logic two_stop_select;
   logic break_request;
   logic rx_ninth_bit;
   logic tx_ninth_bit;
   logic [BAUD_W-1:0] baud_div;

   // Transmit buffer and shifter
   logic [7:0] tx_buf;
   logic tx_buf_nine;
   logic tx_buf_full;
   uffc_pkg::uffc_tx_e tx_state;
   uffc_pkg::uffc_tx_e next_tx_state;
   logic [8:0] shreg;
   logic [3:0] bit_idx;
   logic [3:0] brk_cnt;
   logic [BAUD_W-1:0] baud_cnt;
   logic frame_nine;
   logic frame_two;

   // Receive holding
   logic [7:0] rx_data;
   logic rx_full;
   logic rx_perr;
   logic rx_ferr;
   logic [7:0] rx_byte;
   logic rx_ninth;
   logic rx_ninth_valid;
   logic rx_perr_now;
   logic rx_ferr_now;
   logic rx_done;
   logic rx_idle;

   // Bus decode
   wire wr_ctrl = wr_i && (addr_i == uffc_pkg::ADDR_CTRL);
   wire wr_data = wr_i && (addr_i == uffc_pkg::ADDR_DATA);
   wire wr_baud = wr_i && (addr_i == uffc_pkg::ADDR_BAUD);
   wire rd_data = rd_i && (addr_i == uffc_pkg::ADDR_DATA);

   wire bit_end = (baud_cnt == '0);
   wire tx_load = (tx_state == uffc_pkg::TX_IDLE) && tx_buf_full && enable;
   wire tx_idle = (tx_state == uffc_pkg::TX_IDLE) && !tx_buf_full;
   wire [3:0] last_idx = frame_nine ? uffc_pkg::LAST_BIT9 : uffc_pkg::LAST_BIT8;

   // Frame word: parity replaces the last data slot when enabled
   wire tx_par = uffc_pkg::parity_bit(tx_buf, word_len_nine_select,
                                      parity_odd_select);
   wire [8:0] raw_word = {word_len_nine_select ? tx_buf_nine : 1'b0, tx_buf};
   wire [8:0] par_word = word_len_nine_select ? {tx_par, tx_buf}
                                              : {1'b0, tx_par, tx_buf[6:0]};
   wire [8:0] load_word = parity_enable_bit ? par_word : raw_word;

   wire line_low = (tx_state == uffc_pkg::TX_START) ||
                   (tx_state == uffc_pkg::TX_BREAK);
   wire line_val = (tx_state == uffc_pkg::TX_DATA) ? shreg[0] : !line_low;

   wire [7:0] ctrl_rd = {enable, word_len_nine_select, parity_enable_bit,
                         parity_odd_select, two_stop_select, break_request,
                         rx_ninth_bit, 1'b0};
   wire [7:0] stat_rd = {2'h0, rx_idle, rx_ferr, rx_perr, rx_full, tx_idle, !tx_buf_full};
   wire [7:0] baud_rd = 8'(baud_div);
   wire [7:0] rd_mux = (addr_i == uffc_pkg::ADDR_CTRL) ? ctrl_rd :
                       (addr_i == uffc_pkg::ADDR_DATA) ? rx_data :
                       (addr_i == uffc_pkg::ADDR_STAT) ? stat_rd : baud_rd;

   always_comb begin
      next_tx_state = tx_state;
      case (tx_state)
         uffc_pkg::TX_IDLE: begin
            // Buffered character goes out before any break
            if (tx_buf_full) begin
               next_tx_state = uffc_pkg::TX_START;
            end else if (break_request) begin
               next_tx_state = uffc_pkg::TX_BREAK;
            end
         end
         uffc_pkg::TX_START: begin
            if (bit_end) begin
               next_tx_state = uffc_pkg::TX_DATA;
            end
         end
         uffc_pkg::TX_DATA: begin
            if (bit_end && bit_idx == last_idx) begin
               next_tx_state = uffc_pkg::TX_STOP1;
            end
         end
         uffc_pkg::TX_STOP1: begin
            if (bit_end) begin
               next_tx_state = frame_two ? uffc_pkg::TX_STOP2 : uffc_pkg::TX_IDLE;
            end
         end
         uffc_pkg::TX_STOP2: begin
            if (bit_end) begin
               next_tx_state = uffc_pkg::TX_IDLE;
            end
         end
         uffc_pkg::TX_BREAK: begin
            if (brk_cnt == uffc_pkg::BREAK_BITS && !break_request) begin
               next_tx_state = uffc_pkg::TX_IDLE;
            end
         end
         default: next_tx_state = uffc_pkg::TX_IDLE;
      endcase
   end

   // Control register; disabling also drops a pending break
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         enable <= 1'b0;
         word_len_nine_select <= 1'b0;
         parity_enable_bit <= 1'b0;
         parity_odd_select <= 1'b0;
         two_stop_select <= 1'b0;
         break_request <= 1'b0;
         tx_ninth_bit <= 1'b0;
         baud_div <= uffc_pkg::BAUD_RESET[BAUD_W-1:0];
      end else begin
         if (wr_ctrl) begin
            enable <= wdata_i[uffc_pkg::CTRL_EN];
            word_len_nine_select <= wdata_i[uffc_pkg::CTRL_NINE];
            parity_enable_bit <= wdata_i[uffc_pkg::CTRL_PAREN];
            parity_odd_select <= wdata_i[uffc_pkg::CTRL_ODD];
            two_stop_select <= wdata_i[uffc_pkg::CTRL_TWO];
            break_request <= wdata_i[uffc_pkg::CTRL_BRK] && wdata_i[uffc_pkg::CTRL_EN];
            tx_ninth_bit <= wdata_i[uffc_pkg::CTRL_TX9];
         end
         if (wr_baud) begin
            baud_div <= wdata_i[BAUD_W-1:0];
         end
      end
   end

   // Transmit buffer: a new write wins over the load that empties it
   always_ff @(posedge clock_i) begin
      if (!nrst_i || !enable) begin
         tx_buf <= 8'h00;
         tx_buf_nine <= 1'b0;
         tx_buf_full <= 1'b0;
      end else begin
         if (wr_data) begin
            tx_buf <= wdata_i;
            tx_buf_nine <= tx_ninth_bit;
         end
         tx_buf_full <= wr_data || (tx_buf_full && !tx_load);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i || !enable) begin
         tx_state <= uffc_pkg::TX_IDLE;
         shreg <= 9'h1FF;
         bit_idx <= 4'h0;
         brk_cnt <= 4'h0;
         baud_cnt <= '0;
         frame_nine <= 1'b0;
         frame_two <= 1'b0;
      end else begin
         tx_state <= next_tx_state;
         baud_cnt <= (bit_end || tx_state == uffc_pkg::TX_IDLE) ? baud_div : baud_cnt - 1'b1;
         if (tx_load) begin
            // Format frozen per frame so mid-frame writes are harmless
            shreg <= load_word;
            frame_nine <= word_len_nine_select;
            frame_two <= two_stop_select;
            bit_idx <= 4'h0;
         end else if (tx_state == uffc_pkg::TX_DATA && bit_end) begin
            shreg <= {1'b1, shreg[8:1]};
            bit_idx <= bit_idx + 4'h1;
         end
         if (tx_state != uffc_pkg::TX_BREAK) begin
            brk_cnt <= 4'h0;
         end else if (bit_end && brk_cnt != uffc_pkg::BREAK_BITS) begin
            brk_cnt <= brk_cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         serial_tx_pin_o <= 1'b1;
         serial_tx_oe_o <= 1'b0;
      end else begin
         serial_tx_pin_o <= line_val || !enable;
         serial_tx_oe_o <= enable;
      end
   end

   uffc_rx #(
      .BAUD_W(BAUD_W)
   ) u_uffc_rx (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .enable_i(enable),
      .nine_i(word_len_nine_select),
      .paren_i(parity_enable_bit),
      .odd_i(parity_odd_select),
      .baud_div_i(baud_div),
      .serial_rx_pin_i(serial_rx_pin_i),
      .data_o(rx_byte),
      .ninth_o(rx_ninth),
      .ninth_valid_o(rx_ninth_valid),
      .perr_o(rx_perr_now),
      .ferr_o(rx_ferr_now),
      .done_o(rx_done),
      .idle_o(rx_idle)
   );

   // Receive holding; a fresh character wins over the clearing read
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         rx_data <= 8'h00;
         rx_full <= 1'b0;
         rx_perr <= 1'b0;
         rx_ferr <= 1'b0;
         rx_ninth_bit <= 1'b0;
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= rd_i ? rd_mux : 8'h00;
         rx_full <= enable && (rx_done || (rx_full && !rd_data));
         if (rx_done) begin
            rx_data <= rx_byte;
            rx_perr <= rx_perr_now;
            rx_ferr <= rx_ferr_now;
            if (rx_ninth_valid) begin
               rx_ninth_bit <= rx_ninth;
            end
         end else if (!enable) begin
            rx_perr <= 1'b0;
            rx_ferr <= 1'b0;
         end
      end
   end

   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   parity_type_a: assert property (
      (tx_load && parity_enable_bit && !word_len_nine_select)
      |=> shreg[7] == (^($past(tx_buf) & 8'h7F) ^ $past(parity_odd_select)))
      else $error("parity bit has the wrong sense");
   parity_count_a: assert property (
      (tx_load && parity_enable_bit)
      |=> (frame_nine ? ^shreg : ^shreg[7:0]) == $past(parity_odd_select))
      else $error("ones count in frame does not match parity type");
   stop_count_a: assert property (
      (tx_state == uffc_pkg::TX_STOP1 && bit_end && enable && !wr_ctrl)
      |=> (tx_state == uffc_pkg::TX_STOP2) == $past(frame_two))
      else $error("stop bit count wrong");
   idle_line_a: assert property (
      (tx_state == uffc_pkg::TX_IDLE && enable && !break_request) |=> serial_tx_pin_o)
      else $error("line not high while idle without break");
   break_low_a: assert property (
      (tx_state == uffc_pkg::TX_BREAK && enable) |=> !serial_tx_pin_o)
      else $error("line not low during break");
   break_wait_a: assert property (
      tx_load |=> tx_state == uffc_pkg::TX_START)
      else $error("break started ahead of buffered data");
   break_min_a: assert property (
      (tx_state == uffc_pkg::TX_BREAK && brk_cnt < uffc_pkg::BREAK_BITS && !wr_ctrl)
      |=> tx_state == uffc_pkg::TX_BREAK)
      else $error("break shorter than thirteen bits");
   ninth_send_a: assert property (
      (tx_load && word_len_nine_select && !parity_enable_bit)
      |=> shreg[8] == $past(tx_buf_nine))
      else $error("ninth transmit bit not loaded");
   frame_len_a: assert property (
      (tx_state == uffc_pkg::TX_STOP1 && $past(tx_state) == uffc_pkg::TX_DATA)
      |-> $past(bit_idx) == (frame_nine ? uffc_pkg::LAST_BIT9 : uffc_pkg::LAST_BIT8))
      else $error("data bit count wrong");

   break_seen_c: cover property (tx_state == uffc_pkg::TX_BREAK &&
                                 brk_cnt == uffc_pkg::BREAK_BITS);
   two_stop_c: cover property (tx_state == uffc_pkg::TX_STOP2);
   nine_par_c: cover property (tx_load && word_len_nine_select && parity_enable_bit);
endmodule

/* File: common/uffc_pkg.sv */
package uffc_pkg;
   // Register map, byte-wide registers on a two-bit address
   localparam int ADDR_W = 2;
   localparam int DATA_W = 8;
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_DATA = 2'h1;
   localparam logic [1:0] ADDR_STAT = 2'h2;
   localparam logic [1:0] ADDR_BAUD = 2'h3;

   // Control register fields
   localparam int CTRL_EN = 7;
   localparam int CTRL_NINE = 6;
   localparam int CTRL_PAREN = 5;
   localparam int CTRL_ODD = 4;
   localparam int CTRL_TWO = 3;
   localparam int CTRL_BRK = 2;
   localparam int CTRL_RX9 = 1;
   localparam int CTRL_TX9 = 0;

   // Status register fields
   localparam int STAT_TXE = 0;
   localparam int STAT_TIDLE = 1;
   localparam int STAT_RXF = 2;
   localparam int STAT_PERR = 3;
   localparam int STAT_FERR = 4;
   localparam int STAT_RIDLE = 5;

   localparam logic [7:0] BAUD_RESET = 8'h0F;
   localparam logic [3:0] BREAK_BITS = 4'hD;
   localparam logic [3:0] LAST_BIT8 = 4'h7;
   localparam logic [3:0] LAST_BIT9 = 4'h8;

   typedef enum logic [5:0] {
      TX_IDLE = 6'h01,
      TX_START = 6'h02,
      TX_DATA = 6'h04,
      TX_STOP1 = 6'h08,
      TX_STOP2 = 6'h10,
      TX_BREAK = 6'h20
   } uffc_tx_e;

   typedef enum logic [3:0] {
      RX_IDLE = 4'h1,
      RX_START = 4'h2,
      RX_DATA = 4'h4,
      RX_STOP = 4'h8
   } uffc_rx_e;

   // Parity over the data bits ahead of the parity slot
   function automatic logic parity_bit(input logic [7:0] data, input logic nine,
                                       input logic odd);
      parity_bit = ^(nine ? data : (data & 8'h7F)) ^ odd;
   endfunction
endpackage

/* File: rtl/uffc_rx.sv */
`timescale 1ns/1ps
module uffc_rx #(
   parameter int BAUD_W = 8
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic enable_i,
   input wire logic nine_i,
   input wire logic paren_i,
   input wire logic odd_i,
   input wire logic [BAUD_W-1:0] baud_div_i,
   input wire logic serial_rx_pin_i,
   output logic [7:0] data_o,
   output logic ninth_o,
   output logic ninth_valid_o,
   output logic perr_o,
   output logic ferr_o,
   output logic done_o,
   output logic idle_o
);
   uffc_pkg::uffc_rx_e state;
   uffc_pkg::uffc_rx_e next_state;
   logic rx_meta;
   logic rx_line;
   logic [BAUD_W-1:0] cnt;
   logic [BAUD_W-1:0] next_cnt;
   logic [3:0] idx;
   logic [8:0] sh;
   logic [8:0] next_sh;

   wire cnt_end = (cnt == '0);
   wire [3:0] last_idx = nine_i ? uffc_pkg::LAST_BIT9 : uffc_pkg::LAST_BIT8;
   wire at_stop = (state == uffc_pkg::RX_STOP) && cnt_end;
   wire [8:0] raw = nine_i ? sh : {1'b0, sh[8:1]};
   wire par_rx = nine_i ? raw[8] : raw[7];
   wire par_ok = (par_rx == uffc_pkg::parity_bit(raw[7:0], nine_i, odd_i));
   // Parity slot never reaches data bit 7 or the ninth-bit store
   wire [7:0] data_keep = (!nine_i && paren_i) ? {1'b0, raw[6:0]} : raw[7:0];

   always_comb begin
      next_state = state;
      next_cnt = cnt_end ? baud_div_i : cnt - 1'b1;
      next_sh = sh;
      case (state)
         uffc_pkg::RX_IDLE: begin
            next_cnt = baud_div_i >> 1;
            if (!rx_line) begin
               next_state = uffc_pkg::RX_START;
            end
         end
         uffc_pkg::RX_START: begin
            if (cnt_end) begin
               next_state = rx_line ? uffc_pkg::RX_IDLE : uffc_pkg::RX_DATA;
            end
         end
         uffc_pkg::RX_DATA: begin
            if (cnt_end) begin
               next_sh = {rx_line, sh[8:1]};
               if (idx == last_idx) begin
                  next_state = uffc_pkg::RX_STOP;
               end
            end
         end
         uffc_pkg::RX_STOP: begin
            if (cnt_end) begin
               next_state = uffc_pkg::RX_IDLE;
            end
         end
         default: next_state = uffc_pkg::RX_IDLE;
      endcase
   end

   // Two stages: the pin is asynchronous to clock_i
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         rx_meta <= 1'b1;
         rx_line <= 1'b1;
      end else begin
         rx_meta <= serial_rx_pin_i;
         rx_line <= rx_meta;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i || !enable_i) begin
         state <= uffc_pkg::RX_IDLE;
         cnt <= '0;
         idx <= 4'h0;
         sh <= 9'h000;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         sh <= next_sh;
         if (state == uffc_pkg::RX_START) begin
            idx <= 4'h0;
         end else if (state == uffc_pkg::RX_DATA && cnt_end) begin
            idx <= idx + 4'h1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         data_o <= 8'h00;
         ninth_o <= 1'b0;
         ninth_valid_o <= 1'b0;
         perr_o <= 1'b0;
         ferr_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= at_stop && enable_i;
         if (at_stop) begin
            data_o <= data_keep;
            ninth_o <= raw[8];
            ninth_valid_o <= nine_i && !paren_i;
            perr_o <= paren_i && !par_ok;
            ferr_o <= !rx_line;
         end
      end
   end

   assign idle_o = (state == uffc_pkg::RX_IDLE);

   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   rx_ninth_keep_a: assert property (
      (at_stop && enable_i && nine_i) |=> ninth_valid_o == !$past(paren_i))
      else $error("ninth bit validity wrong");
   rx_par_drop_a: assert property (
      (at_stop && enable_i && !nine_i && paren_i) |=> !data_o[7])
      else $error("parity bit leaked into data bit 7");
   rx_frame_c: cover property (done_o && nine_i);
endmodule

/* File: tb/uffc_remote_node.sv */
`timescale 1ns/1ps
module uffc_remote_node #(
   parameter int P = 8
) (
   input wire logic clock_i,
   input wire logic line_i,
   input wire logic nine_i,
   output logic rx_line_o,
   output int frame_seq_o,
   output logic [11:0] frame_o
);
   int cyc = 0;
   int t0;
   int cnt;
   logic skip = 1'b0;
   logic [8:0] bits;

   initial begin
      rx_line_o = 1'b1;
      frame_seq_o = 0;
      frame_o = 12'h000;
   end

   always @(posedge clock_i) begin
      cyc <= cyc + 1;
   end

   // Caller sits just after a rising edge; idle level is high
   task automatic send_frame(input logic [8:0] slots, input int n, input int stops);
      rx_line_o <= 1'b0;
      repeat (P) @(posedge clock_i);
      for (int i = 0; i < n; i++) begin
         rx_line_o <= slots[i];
         repeat (P) @(posedge clock_i);
      end
      rx_line_o <= 1'b1;
      repeat (P * stops) @(posedge clock_i);
   endtask

   // Frames followed at once by a start skip the edge wait, so timing stays exact
   initial forever begin
      if (!skip) @(posedge clock_i);
      skip = 1'b0;
      if (line_i === 1'b0) begin
         t0 = cyc;
         bits = 9'h000;
         repeat (P / 2) @(posedge clock_i);
         for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
            repeat (P) @(posedge clock_i);
            bits[i] = line_i;
         end
         repeat (P) @(posedge clock_i);
         cnt = 0;
         if (line_i === 1'b1) begin
            while (line_i === 1'b1 && cnt < 3 * P) begin
               @(posedge clock_i);
               cnt++;
            end
            skip = (line_i === 1'b0);
            frame_o <= {1'b0, 2'((cnt + P / 2) / P), bits};
         end else begin
            while (line_i !== 1'b1 && cnt < 40 * P) begin
               @(posedge clock_i);
               cnt++;
            end
            frame_o <= {1'b1, 2'b00, 9'((cyc - t0) >= 13 * P)};
         end
         frame_seq_o <= frame_seq_o + 1;
      end
   end
endmodule

/* File: tb/uffc_tb_top.sv */
`timescale 1ns/1ps
module uffc_tb_top;
   localparam int P = 8;
   typedef struct {logic [7:0] exp; logic [7:0] mask;} uffc_note_s;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic tx_pin;
   logic tx_oe;
   logic rx_pin;
   logic line;
   logic nine = 1'b0;
   logic [11:0] frame;
   int frame_seq;
   int seen_seq = 0;
   logic rd_seen = 1'b0;
   int errors = 0;
   int comparisons = 0;
   logic [31:0] rng = 32'h000158D6;
   logic [31:0] r;
   logic [7:0] got;
   uffc_note_s note;
   uffc_note_s bus_q[$];
   logic [11:0] ser_q[$];
   logic [7:0] rx_cfg [5] = '{8'hC0, 8'hE0, 8'hB0, 8'h80, 8'hC0};
   logic [8:0] rx_slots [5] = '{9'h1A5, 9'h03C, 9'h0DA, 9'h0C3, 9'h07E};
   logic [7:0] rx_nine [5] = '{8'h02, 8'h02, 8'h00, 8'h00, 8'h00};
   logic [7:0] rx_mask [5] = '{8'hFF, 8'hFF, 8'hFD, 8'hFD, 8'hFF};
   logic [7:0] rx_data [5] = '{8'hA5, 8'h3C, 8'h5A, 8'hC3, 8'h7E};

   // Released line idles high through its pull-up
   assign line = tx_oe ? tx_pin : 1'b1;

   uffc_top u_uffc_top (
      .clock_i(clock),
      .nrst_i(nrst),
      .addr_i(addr),
      .wdata_i(wdata),
      .wr_i(wr),
      .rd_i(rd),
      .rdata_o(rdata),
      .serial_tx_pin_o(tx_pin),
      .serial_tx_oe_o(tx_oe),
      .serial_rx_pin_i(rx_pin)
   );

   uffc_remote_node #(.P(P)) u_uffc_remote_node (
      .clock_i(clock),
      .line_i(line),
      .nine_i(nine),
      .rx_line_o(rx_pin),
      .frame_seq_o(frame_seq),
      .frame_o(frame)
   );

   initial begin
      forever #10 clock = ~clock;
   end

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   // Slot layout on the wire, parity worked out here from the data bits
   function automatic logic [11:0] exp_frame(input logic [7:0] d, input logic [3:0] k,
                                             input logic t9, input logic [1:0] st);
      logic [8:0] s;
      if (k[3]) begin
         s = {k[2] ? (^d ^ k[1]) : t9, d};
      end else begin
         s = {1'b0, k[2] ? (^d[6:0] ^ k[1]) : d[7], d[6:0]};
      end
      return {1'b0, st, s};
   endfunction

   task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [1:0] a, input logic [7:0] exp, input logic [7:0] mask,
                         output logic [7:0] val);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      bus_q.push_back('{exp, mask});
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      val = rdata;
   endtask

   task automatic wait_ser(input int n);
      for (int i = 0; i < 3000 && ser_q.size() > n; i++) @(posedge clock);
      if (ser_q.size() > n) begin
         errors++;
         end_sim();
      end
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge clock) begin
      rd_seen <= rd;
   end

   // Looked at mid-cycle, clear of the edge that launches the outputs
   always @(negedge clock) begin
      if (rd_seen) begin
         note = bus_q.pop_front();
         check(12'(rdata & note.mask), 12'(note.exp & note.mask));
      end
      if (frame_seq != seen_seq) begin
         seen_seq = frame_seq;
         if (ser_q.size() == 0) begin
            check(frame, frame ^ 12'hFFF);
         end else begin
            check(frame, ser_q.pop_front());
         end
      end
   end

   initial begin
      repeat (100000) @(posedge clock);
      errors++;
      end_sim();
   end

   initial begin
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      @(negedge clock);
      check(12'({tx_oe, tx_pin}), 12'h001);
      bus_rd(uffc_pkg::ADDR_CTRL, 8'h00, 8'hFF, got);
      bus_rd(uffc_pkg::ADDR_BAUD, uffc_pkg::BAUD_RESET, 8'hFF, got);
      bus_wr(uffc_pkg::ADDR_CTRL, 8'h01);
      bus_rd(uffc_pkg::ADDR_CTRL, 8'h00, 8'hFF, got);
      bus_wr(uffc_pkg::ADDR_BAUD, 8'(P - 1));
      bus_rd(uffc_pkg::ADDR_BAUD, 8'(P - 1), 8'hFF, got);
      // Every format: two frames back to back, ninth bit changed between writes
      for (int k = 0; k < 16; k++) begin
         nine = k[3];
         r = xs();
         bus_wr(uffc_pkg::ADDR_CTRL, {1'b1, 4'(k), 2'b00, r[8]});
         ser_q.push_back(exp_frame(r[7:0], 4'(k), r[8], k[0] ? 2'h2 : 2'h1));
         bus_wr(uffc_pkg::ADDR_DATA, r[7:0]);
         bus_wr(uffc_pkg::ADDR_CTRL, {1'b1, 4'(k), 2'b00, r[9]});
         ser_q.push_back(exp_frame(r[17:10], 4'(k), r[9], 2'h3));
         bus_wr(uffc_pkg::ADDR_DATA, r[17:10]);
         wait_ser(0);
         @(negedge clock);
         check(12'({tx_oe, tx_pin}), 12'h003);
      end
      // Break asked for mid-frame and dropped early: frame first, then the minimum low time
      nine = 1'b0;
      r = xs();
      bus_wr(uffc_pkg::ADDR_CTRL, 8'h80);
      ser_q.push_back(exp_frame(r[7:0], 4'h0, 1'b0, 2'h1));
      bus_wr(uffc_pkg::ADDR_DATA, r[7:0]);
      bus_wr(uffc_pkg::ADDR_CTRL, 8'h84);
      ser_q.push_back(12'h801);
      wait_ser(1);
      repeat (2 * P) @(posedge clock);
      bus_wr(uffc_pkg::ADDR_CTRL, 8'h80);
      wait_ser(0);
      ser_q.push_back(exp_frame(r[15:8], 4'h0, 1'b0, 2'h3));
      bus_wr(uffc_pkg::ADDR_DATA, r[15:8]);
      wait_ser(0);
      // Receive side: ninth bit kept, parity slot never stored
      for (int j = 0; j < 5; j++) begin
         bus_wr(uffc_pkg::ADDR_CTRL, rx_cfg[j]);
         u_uffc_remote_node.send_frame(rx_slots[j], rx_cfg[j][6] ? 9 : 8, 1);
         got = 8'h00;
         for (int i = 0; i < 50 && got[uffc_pkg::STAT_RXF] !== 1'b1; i++) begin
            bus_rd(uffc_pkg::ADDR_STAT, 8'h00, 8'h18, got);
         end
         if (got[uffc_pkg::STAT_RXF] !== 1'b1) begin
            errors++;
            end_sim();
         end
         bus_rd(uffc_pkg::ADDR_CTRL, rx_cfg[j] | rx_nine[j], rx_mask[j], got);
         bus_rd(uffc_pkg::ADDR_DATA, rx_data[j], 8'hFF, got);
      end
      repeat (4) @(posedge clock);
      end_sim();
   end
endmodule
